/* File: bhfi_master.sv */
module bhfi_master (
  input  wire logic mclk_in,   // clock
  input  wire logic want_in,   // master wants bus
  input  wire logic ack_n_in,  // ack pin
  output logic      hold_n_out, // request
  output logic      owns_out    // bus in use
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // request stays high outside use, never floats
  initial hold_n_out = 1'b1;
  initial owns_out = 1'b0;
  always @(negedge mclk_in) begin
    hold_n_out <= !want_in;
    owns_out <= !ack_n_in && !hold_n_out && want_in;
  end
endmodule // bhfi_master

/* File: bhfi_pkg.sv */
package bhfi_pkg;
  // ==========================================
  // pin numbers on the shared port
  localparam int unsigned HOLD_REQ_PIN     = 5;
  localparam int unsigned HOLD_ACK_PIN     = 6;
  localparam int unsigned CYCLE_PEND_PIN   = 3;
  localparam int unsigned PORT_WIDTH       = 8;
  // ==========================================
  // reset values
  localparam logic        HOLD_EN_RST      = 1'b0;
  localparam logic [7:0]  PORT_REG_RST     = 8'h00;
  // ==========================================
  // hold state machine
  typedef enum logic [1:0] {
    BHFI_OWN,
    BHFI_DRAIN,
    BHFI_HELD,
    BHFI_RELEASE
  } bhfi_state_type;
endpackage

/* File: bhfi_props.sv */
module bhfi_props
  import bhfi_pkg::*;
(
  input wire logic                  mclk_in,                   // clk
  input wire logic                  rst_in,                    // rst
  input wire logic                  ext_cycle_req_in,          // want
  input wire logic                  ext_cycle_fetch_in,        // kind
  input wire logic                  ext_cycle_done_in,         // end
  input wire logic [PORT_WIDTH-1:0] port2_pin_out,             // lvl
  input wire logic [PORT_WIDTH-1:0] port2_pin_oe_out,          // oe
  input wire logic [PORT_WIDTH-1:0] port2_pin_sync_out,        // sync
  input wire logic                  hold_protocol_enable_out,  // en
  input wire logic                  bus_granted_out,           // own
  input wire logic                  ext_cycle_active_out,      // cyc
  input wire logic                  instruction_fetch_flag_out // flag
);
  // ==========
  // checks
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  wire en = hold_protocol_enable_out;
  wire ack = !port2_pin_out[6];
  sequence ack_up; $rose(port2_pin_out[6]) && !bus_granted_out; endsequence
  sequence take_back; !bus_granted_out ##1 bus_granted_out; endsequence
  a_req_pin_locked: assert property ($past(en) && en |-> !port2_pin_oe_out[5])
    else $error("hold request pin driven");
  a_ack_pin_locked: assert property ($past(en) && en |-> port2_pin_oe_out[6])
    else $error("ack pin not driven");
  a_pend_pin_locked: assert property ($past(en) && en |-> port2_pin_oe_out[3])
    else $error("pending pin not driven");
  a_ack_answers: assert property (en && $fell(port2_pin_sync_out[5]) && !ext_cycle_active_out |-> ##[0:4] ack)
    else $error("ack late");
  a_ack_bus_free: assert property ($past(en) && en && ack |-> !bus_granted_out && !ext_cycle_active_out)
    else $error("bus used while ack low");
  a_regrant_order: assert property (ack_up |-> take_back)
    else $error("bus retaken out of order");
  a_flag_in_cycle: assert property (instruction_fetch_flag_out |-> ext_cycle_active_out)
    else $error("flag outside cycle");
  a_flag_kind: assert property ($rose(ext_cycle_active_out) |-> instruction_fetch_flag_out == $past(ext_cycle_fetch_in))
    else $error("flag wrong kind");
  a_flag_stands: assert property (instruction_fetch_flag_out && !ext_cycle_done_in |=> instruction_fetch_flag_out)
    else $error("flag dropped");
  a_pend_shown: assert property ($past(en) && ack && $past(ext_cycle_req_in) |-> !port2_pin_out[3])
    else $error("pending not shown");
endmodule // bhfi_props
bind bhfi_top bhfi_props i_props (.mclk_in, .rst_in, .ext_cycle_req_in, .ext_cycle_fetch_in,
  .ext_cycle_done_in, .port2_pin_out, .port2_pin_oe_out, .port2_pin_sync_out,
  .hold_protocol_enable_out, .bus_granted_out, .ext_cycle_active_out, .instruction_fetch_flag_out);

/* File: bhfi_sync.sv */
module bhfi_sync (
  input  wire logic mclk_in,   // clock
  input  wire logic rst_in,    // async reset
  input  wire logic async_in,  // raw pin level
  output logic      sync_out   // synchronised level
);
  logic meta_q;
  logic sync_q;
  // reset value high: an idle active-low pin
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end
  assign sync_out = sync_q;
endmodule // bhfi_sync

/* File: bhfi_tb.sv */
module bus_hold_and_fetch_indicator_tb;
  import bhfi_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic en_wr, en_d, cfg_wr, req, fetch, done, want, hold_n, owns, hen, granted, active, flag;
  logic [PORT_WIDTH-1:0] dir, pin_out, oe;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  logic [1:0] rows [3] = '{2'b11, 2'b00, 2'b11}; // fetch, expected flag
  always #12.5 mclk_in = ~mclk_in;
  bhfi_top i_dut (.mclk_in, .rst_in, .hold_enable_wr_in(en_wr), .hold_enable_data_in(en_d),
    .port_cfg_wr_in(cfg_wr), .port2_function_select_in(8'h00), .port2_direction_in(dir),
    .port2_output_latch_in(8'h00), .port2_pin_in({2'b11, hold_n, 5'h1f}),
    .ext_cycle_req_in(req), .ext_cycle_fetch_in(fetch), .ext_cycle_done_in(done),
    .port2_pin_out(pin_out), .port2_pin_oe_out(oe), .port2_pin_sync_out(),
    .hold_protocol_enable_out(hen), .bus_granted_out(granted),
    .ext_cycle_active_out(active), .instruction_fetch_flag_out(flag));
  bhfi_master i_master (.mclk_in, .want_in(want), .ack_n_in(pin_out[6]),
    .hold_n_out(hold_n), .owns_out(owns));
  // ==========
  // helpers
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic e, input logic s);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s exp %b got %b", nm, e, s);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge mclk_in);
  endtask
  task automatic cyc(input logic f, input logic e);
    {req, fetch} = {1'b1, f};
    while (active !== 1'b1) step(1);
    req = 1'b0;
    repeat (2) begin
      chk("fetch flag", e, flag);
      step(1);
    end
    done = 1'b1;
    step(1);
    done = 1'b0;
    chk("idle flag", 1'b0, flag);
  endtask
  // whole run is under a hundred cycles
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  initial begin
    {en_wr, en_d, cfg_wr, req, fetch, done, want} = '0;
    dir = 8'hff;
    step(8);
    chk("reset grant", 1'b1, granted);
    rst_in = 1'b0;
    foreach (rows[i]) cyc(rows[i][1], rows[i][0]);
    $display("test cycles done");
    cfg_wr = 1'b1;
    step(1);
    {cfg_wr, en_wr, en_d} = 3'b011;
    step(1);
    {en_wr, cfg_wr, dir} = {2'b01, 8'h00};
    step(1);
    cfg_wr = 1'b0;
    step(3);
    chk("enable bit", 1'b1, hen);
    chk("free pin oe", 1'b0, oe[0]);
    chk("req pin oe", 1'b0, oe[5]);
    chk("ack pin oe", 1'b1, oe[6]);
    chk("ack idle", 1'b1, pin_out[6]);
    chk("pend pin oe", 1'b1, oe[3]);
    want = 1'b1;
    while (pin_out[6] !== 1'b0) step(1);
    req = 1'b1;
    step(2);
    chk("held grant", 1'b0, granted);
    chk("held cycle", 1'b0, active);
    chk("pending", 1'b0, pin_out[3]);
    chk("master owns", 1'b1, owns);
    step(20);
    want = 1'b0;
    while (pin_out[6] !== 1'b1) step(1);
    chk("grant after ack", 1'b0, granted);
    cyc(1'b0, 1'b0);
    {en_wr, en_d} = 2'b10;
    step(1);
    en_wr = 1'b0;
    step(3);
    chk("restored oe", 1'b1, oe[5]);
    chk("enable cleared", 1'b0, hen);
    $display("test hold done");
    tally_and_finish();
  end
endmodule // bus_hold_and_fetch_indicator_tb

/* File: bhfi_top.sv */
// How it works
// [R1] hold enable locks pin5 to hold request
// [R2] hold enable locks pin6 to acknowledge
// [R3] port config writes to pins 3, 5 and 6 ignored while enabled
// [R4] outside master requests bus driving low
// [R5] acknowledge low after bus released
// [R6] fetch flag high whole external fetch
// [R7] fetch flag low on data accesses
// [R8] fetch flag low for internal fetches
// [R9] cycle pending low while held, pin locked
// [R10] acknowledge rises before device resumes bus
module bhfi_top
  import bhfi_pkg::*;
(
  input  wire logic                  mclk_in,              // 40 MHz clock
  input  wire logic                  rst_in,               // async reset, high
  input  wire logic                  hold_enable_wr_in,    // write strobe for enable bit
  input  wire logic                  hold_enable_data_in,  // value for enable bit
  input  wire logic                  port_cfg_wr_in,       // port config write strobe
  input  wire logic [PORT_WIDTH-1:0] port2_function_select_in, // mode write data
  input  wire logic [PORT_WIDTH-1:0] port2_direction_in,   // direction write data
  input  wire logic [PORT_WIDTH-1:0] port2_output_latch_in, // latch write data
  input  wire logic [PORT_WIDTH-1:0] port2_pin_in,         // raw pin levels
  input  wire logic                  ext_cycle_req_in,     // controller wants a cycle
  input  wire logic                  ext_cycle_fetch_in,   // wanted cycle is a fetch
  input  wire logic                  ext_cycle_done_in,    // current cycle ends
  output logic [PORT_WIDTH-1:0]      port2_pin_out,        // pin output levels
  output logic [PORT_WIDTH-1:0]      port2_pin_oe_out,     // pin drive enables
  output logic [PORT_WIDTH-1:0]      port2_pin_sync_out,   // synchronised pin levels
  output logic                       hold_protocol_enable_out, // enable bit state
  output logic                       bus_granted_out,      // device owns the bus
  output logic                       ext_cycle_active_out, // external cycle running
  output logic                       instruction_fetch_flag_out // fetch indicator
);
  import bhfi_pkg::*;

  // ==========================================
  // pin synchronisers
  logic [PORT_WIDTH-1:0] pin_sync;
  genvar gi;
  generate
    for (gi = 0; gi < PORT_WIDTH; gi++) begin : g_sync
      bhfi_sync u_sync (
        .mclk_in  (mclk_in),
        .rst_in   (rst_in),
        .async_in (port2_pin_in[gi]),
        .sync_out (pin_sync[gi])
      );
    end
  endgenerate

  // ==========================================
  // configuration state
  logic                  hold_en_q;
  logic                  hold_en_d;
  logic [PORT_WIDTH-1:0] mode_q;
  logic [PORT_WIDTH-1:0] mode_d;
  logic [PORT_WIDTH-1:0] dir_q;
  logic [PORT_WIDTH-1:0] dir_d;
  logic [PORT_WIDTH-1:0] latch_q;
  logic [PORT_WIDTH-1:0] latch_d;

  always_comb begin
    hold_en_d = hold_en_q;
    mode_d    = mode_q;
    dir_d     = dir_q;
    latch_d   = latch_q;
    if (hold_enable_wr_in) begin
      hold_en_d = hold_enable_data_in;
    end
    // locked pins keep their config; other pins still take writes
    if (port_cfg_wr_in) begin
      for (int i = 0; i < PORT_WIDTH; i++) begin
        if (!(hold_en_q && (i == HOLD_REQ_PIN || i == HOLD_ACK_PIN
                            || i == CYCLE_PEND_PIN))) begin // R3
          mode_d[i]  = port2_function_select_in[i];
          dir_d[i]   = port2_direction_in[i];
          latch_d[i] = port2_output_latch_in[i];
        end
      end
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      hold_en_q <= HOLD_EN_RST;
      mode_q    <= PORT_REG_RST;
      dir_q     <= PORT_REG_RST;
      latch_q   <= PORT_REG_RST;
    end else begin
      hold_en_q <= hold_en_d;
      mode_q    <= mode_d;
      dir_q     <= dir_d;
      latch_q   <= latch_d;
    end
  end

  // ==========================================
  // hold arbitration
  bhfi_state_type state_q;
  bhfi_state_type state_d;
  logic           cyc_q;
  logic           cyc_d;
  logic           fetch_q;
  logic           fetch_d;
  logic           hold_req;

  // request only counts with the protocol on; pin 5 is input then
  assign hold_req = hold_en_q && !pin_sync[HOLD_REQ_PIN]; // R1 R4

  always_comb begin
    state_d = state_q;
    cyc_d   = cyc_q;
    fetch_d = fetch_q;
    // an external cycle in flight always completes before release
    if (cyc_q && ext_cycle_done_in) begin
      cyc_d   = 1'b0;
      fetch_d = 1'b0; // R8
    end
    case (state_q)
      BHFI_OWN: begin
        if (hold_req) begin
          state_d = BHFI_DRAIN;
        end else if (!cyc_d && ext_cycle_req_in) begin
          cyc_d   = 1'b1;
          fetch_d = ext_cycle_fetch_in; // R6 R7
        end
      end
      BHFI_DRAIN: begin
        if (!cyc_d) begin
          state_d = BHFI_HELD; // R5
        end
      end
      BHFI_HELD: begin
        if (!hold_req) begin
          state_d = BHFI_RELEASE; // R10
        end
      end
      BHFI_RELEASE: begin
        // one cycle with ack high and bus still floated
        state_d = BHFI_OWN; // R10
      end
      default: begin
        state_d = BHFI_OWN;
      end
    endcase
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= BHFI_OWN;
      cyc_q   <= 1'b0;
      fetch_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cyc_q   <= cyc_d;
      fetch_q <= fetch_d;
    end
  end

  // ==========================================
  // pin drive, registered
  // every pin level and enable leaves a flop fed from the next state, so the
  // locked pins change on the same edge as the hold state; the acknowledge
  // therefore falls on the edge the drain ends, never before it.
  // limitation: with the protocol off, pins 3, 5 and 6 are plain
  // port pins and the hold request is ignored entirely.
  // trade-off: the stored config of locked pins is kept, not
  // overwritten, so clearing the enable restores the old setup.
  logic [PORT_WIDTH-1:0] pin_out_q;
  logic [PORT_WIDTH-1:0] pin_out_d;
  logic [PORT_WIDTH-1:0] pin_oe_q;
  logic [PORT_WIDTH-1:0] pin_oe_d;
  logic [PORT_WIDTH-1:0] pin_sync_q;
  logic                  granted_q;
  logic                  granted_d;

  always_comb begin
    pin_out_d = latch_q;
    pin_oe_d  = dir_q;
    granted_d = (state_d == BHFI_OWN);
    if (hold_en_q) begin
      pin_oe_d[HOLD_REQ_PIN]    = 1'b0; // R1
      pin_out_d[HOLD_REQ_PIN]   = 1'b1; // R1
      pin_oe_d[HOLD_ACK_PIN]    = 1'b1; // R2
      pin_out_d[HOLD_ACK_PIN]   = (state_d != BHFI_HELD); // R2 R5 R10
      pin_oe_d[CYCLE_PEND_PIN]  = 1'b1; // R9
      pin_out_d[CYCLE_PEND_PIN] = !((state_d == BHFI_HELD) && ext_cycle_req_in); // R9
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_out_q  <= PORT_REG_RST;
      pin_oe_q   <= PORT_REG_RST;
      pin_sync_q <= PORT_REG_RST;
      granted_q  <= 1'b1;
    end else begin
      pin_out_q  <= pin_out_d;
      pin_oe_q   <= pin_oe_d;
      pin_sync_q <= pin_sync;
      granted_q  <= granted_d;
    end
  end

  assign port2_pin_out              = pin_out_q;
  assign port2_pin_oe_out           = pin_oe_q;
  assign port2_pin_sync_out         = pin_sync_q;
  assign hold_protocol_enable_out   = hold_en_q;
  assign bus_granted_out            = granted_q;
  assign ext_cycle_active_out       = cyc_q;
  assign instruction_fetch_flag_out = fetch_q; // R6 R7 R8
endmodule // bhfi_top
